/* File: hw/fqtr_cnt.v */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// loadable down counter used to time each bus phase
// ----------------------------------------------------------------------
module fqtr_cnt #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         load,
    input  wire [W-1:0] value,
    output wire         zero
);
    reg [W-1:0] count_reg;  // cycles left in the phase

    // load wins, otherwise count down and stop at zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= {W{1'b0}};
        end else if (load) begin
            count_reg <= value;
        end else if (count_reg != {W{1'b0}}) begin
            count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign zero = (count_reg == {W{1'b0}});
endmodule

`default_nettype wire

/* File: hw/fqtr_host.v */
`timescale 1ns/10ps
`default_nettype none
`include "fqtr_host_regs.vh"

// Function
// - write 98h to enter query
// - reset command leaves query to read
// - query from autoselect returns to autoselect
// - recover unknown state with reset
// - write needs CE, WE low, OE high
module fqtr_host #(
    parameter AW     = 23,
    parameter PU_CYC = (`FQTR_T_PU_NS + `FQTR_CLK_NS - 1) / `FQTR_CLK_NS
) (
    input  wire          CLOCK,
    input  wire          RST_N,
    input  wire [7:0]    S_AXI_AWADDR,
    input  wire          S_AXI_AWVALID,
    output wire          S_AXI_AWREADY,
    input  wire [31:0]   S_AXI_WDATA,
    input  wire [3:0]    S_AXI_WSTRB,
    input  wire          S_AXI_WVALID,
    output wire          S_AXI_WREADY,
    output wire [1:0]    S_AXI_BRESP,
    output wire          S_AXI_BVALID,
    input  wire          S_AXI_BREADY,
    input  wire [7:0]    S_AXI_ARADDR,
    input  wire          S_AXI_ARVALID,
    output wire          S_AXI_ARREADY,
    output wire [31:0]   S_AXI_RDATA,
    output wire [1:0]    S_AXI_RRESP,
    output wire          S_AXI_RVALID,
    input  wire          S_AXI_RREADY,
    output wire [AW-1:0] FLASH_ADDR,
    output wire          FLASH_CE_N,
    output wire          FLASH_WE_N,
    output wire          FLASH_OE_N,
    input  wire [7:0]    FLASH_DQ_IN,
    output wire [7:0]    FLASH_DQ_OUT,
    output wire          FLASH_DQ_OE
);
    // ------------------------------------------------------------------
    // phase lengths in cycles, least times rounded up
    // ------------------------------------------------------------------
    localparam AS_CYC  = (`FQTR_T_AS_NS + `FQTR_CLK_NS - 1) / `FQTR_CLK_NS;
    localparam WP_CYC  = (`FQTR_T_WP_NS + `FQTR_CLK_NS - 1) / `FQTR_CLK_NS;
    localparam DH_CYC  = (`FQTR_T_DH_NS + `FQTR_CLK_NS - 1) / `FQTR_CLK_NS;
    localparam ACC_CYC = (`FQTR_T_ACC_NS + `FQTR_CLK_NS - 1) / `FQTR_CLK_NS;

    localparam [2:0] S_PU = 3'd0, S_IDLE = 3'd1, S_WSET = 3'd2, S_WPUL = 3'd3;
    localparam [2:0] S_WHLD = 3'd4, S_RSET = 3'd5, S_RPUL = 3'd6;

    // ------------------------------------------------------------------
    // expected query table contents
    // ------------------------------------------------------------------
    function [7:0] tbl_byte;
        input [7:0] a;
        begin
            case (a)
                8'h10: tbl_byte = 8'h51;
                8'h11: tbl_byte = 8'h52;
                8'h12: tbl_byte = 8'h59;
                8'h13: tbl_byte = 8'h02;
                8'h15: tbl_byte = 8'h40;
                8'h1b: tbl_byte = 8'h27;
                8'h1c: tbl_byte = 8'h36;
                8'h1f: tbl_byte = 8'h04;
                8'h21: tbl_byte = 8'h0a;
                8'h23: tbl_byte = 8'h05;
                8'h25: tbl_byte = 8'h04;
                8'h27: tbl_byte = 8'h17;
                8'h2c: tbl_byte = 8'h01;
                8'h2d: tbl_byte = 8'h7f;
                8'h30: tbl_byte = 8'h01;
                8'h40: tbl_byte = 8'h50;
                8'h41: tbl_byte = 8'h52;
                8'h42: tbl_byte = 8'h49;
                8'h43: tbl_byte = 8'h31;
                8'h44: tbl_byte = 8'h31;
                8'h45: tbl_byte = 8'h01;
                8'h46: tbl_byte = 8'h02;
                8'h47: tbl_byte = 8'h04;
                8'h48: tbl_byte = 8'h01;
                8'h49: tbl_byte = 8'h04;
                8'h4d: tbl_byte = 8'hb5;
                8'h4e: tbl_byte = 8'hc5;
                default: tbl_byte = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg [2:0]    state_reg;          // phase machine
    reg [2:0]    state_next;
    reg [AW-1:0] addr_reg;           // target flash address
    reg [7:0]    wdata_reg;          // byte to write
    reg [7:0]    rdata_reg;          // last byte read
    reg          wr_reg;             // operation kind, 1 = write
    reg          query_reg;          // device believed in query mode
    reg          autosel_reg;        // device believed in autoselect
    reg          mism_reg;           // sticky table mismatch
    reg          pu_armed_reg;       // power-up count loaded
    reg          ce_n_reg;
    reg          we_n_reg;
    reg          oe_n_reg;
    reg          dq_oe_reg;
    reg          cnt_load;           // start of a phase
    reg [7:0]    cnt_value;          // phase length minus one
    wire         cnt_zero;
    wire [7:0]   dq_sync;            // flash data after two flops

    // AXI slave state
    reg          aw_hold_reg;        // write address captured
    reg          w_hold_reg;         // write data captured
    reg [7:0]    aw_addr_reg;
    reg [31:0]   w_data_reg;
    reg [3:0]    w_strb_reg;
    reg          bvalid_reg;
    reg [1:0]    bresp_reg;
    reg          rvalid_reg;
    reg [1:0]    rresp_reg;
    reg [31:0]   rdata_bus_reg;

    wire        do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                         {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire        busy = (state_reg != S_IDLE);
    wire        go = do_write && (aw_addr_reg == `FQTR_REG_CTRL) && w_strb_reg[0]
                     && w_data_reg[`FQTR_CTRL_GO] && !busy;
    wire [7:0]  wbyte_low = w_data_reg[7:0];
    wire [31:0] status = {27'h0, (state_reg == S_PU), mism_reg, autosel_reg,
                          query_reg, busy};
    wire        tbl_hit = query_reg && (addr_reg[AW-1:8] == {(AW-8){1'b0}})
                          && (addr_reg[7:0] >= `FQTR_TBL_FIRST)
                          && (addr_reg[7:0] <= `FQTR_TBL_LAST);
    wire        capture = (state_reg == S_RPUL) && cnt_zero;
    wire        done_wr = (state_reg == S_WHLD) && cnt_zero;
    wire        mism_set = capture && tbl_hit && (dq_sync != tbl_byte(addr_reg[7:0]));
    wire        mism_clr = do_write && (aw_addr_reg == `FQTR_REG_STATUS)
                           && w_strb_reg[0] && w_data_reg[`FQTR_ST_MISMATCH];

    fqtr_sync #(.W(8)) u_dq_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .din   (FLASH_DQ_IN),
        .dout  (dq_sync)
    );

    fqtr_cnt #(.W(8)) u_phase_cnt (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .load  (cnt_load),
        .value (cnt_value),
        .zero  (cnt_zero)
    );

    // ------------------------------------------------------------------
    // phase machine, next state and counter loads
    // ------------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        cnt_load   = 1'b0;
        cnt_value  = 8'h00;
        case (state_reg)
            // strobes idle until power-up wait ends
            S_PU: begin
                if (!pu_armed_reg) begin
                    cnt_load   = 1'b1;
                    cnt_value  = PU_CYC[7:0] - 8'h01;
                end else if (cnt_zero) begin
                    state_next = S_IDLE;
                end
            end
            S_IDLE: begin
                if (go) begin
                    // address drives before any strobe falls
                    state_next = w_data_reg[`FQTR_CTRL_WR] ? S_WSET : S_RSET;
                    cnt_load   = 1'b1;
                    cnt_value  = AS_CYC[7:0] - 8'h01;
                end
            end
            S_WSET: begin
                if (cnt_zero) begin
                    state_next = S_WPUL;
                    cnt_load   = 1'b1;
                    cnt_value  = WP_CYC[7:0] - 8'h01;
                end
            end
            S_WPUL: begin
                if (cnt_zero) begin
                    state_next = S_WHLD;
                    cnt_load   = 1'b1;
                    cnt_value  = DH_CYC[7:0] - 8'h01;
                end
            end
            S_WHLD: begin
                if (cnt_zero) begin
                    state_next = S_IDLE;
                end
            end
            S_RSET: begin
                if (cnt_zero) begin
                    // access time plus two synchroniser cycles
                    state_next = S_RPUL;
                    cnt_load   = 1'b1;
                    cnt_value  = ACC_CYC[7:0] + 8'h01;
                end
            end
            S_RPUL: begin
                if (cnt_zero) begin
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // flash pins and mode tracking
    // ------------------------------------------------------------------
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg   <= S_PU;
            ce_n_reg    <= 1'b1;
            we_n_reg    <= 1'b1;
            oe_n_reg    <= 1'b1;
            dq_oe_reg   <= 1'b0;
            rdata_reg   <= `FQTR_BYTE_RST;
            // device comes up in array read
            query_reg   <= 1'b0;
            autosel_reg <= 1'b0;
            mism_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            // write: CE, WE low and OE high only in pulse
            ce_n_reg  <= !(state_next == S_WPUL || state_next == S_RPUL);
            we_n_reg  <= !(state_next == S_WPUL);
            // reads keep WE high, CE and OE low
            oe_n_reg  <= !(state_next == S_RPUL);
            dq_oe_reg <= (state_next == S_WSET || state_next == S_WPUL
                          || state_next == S_WHLD);
            if (capture) begin
                rdata_reg <= dq_sync;
            end
            // hardware set wins over software clear
            if (mism_set) begin
                mism_reg <= 1'b1;
            end else if (mism_clr) begin
                mism_reg <= 1'b0;
            end
            if (done_wr) begin
                // query entry from read or autoselect
                if (wdata_reg == `FQTR_CMD_QUERY) begin
                    query_reg <= 1'b1;
                end else if (wdata_reg == `FQTR_CMD_RESET) begin
                    if (query_reg) begin
                        query_reg <= 1'b0;
                    end else begin
                        autosel_reg <= 1'b0;
                    end
                end else if (wdata_reg == `FQTR_CMD_AUTOSEL && !query_reg) begin
                    autosel_reg <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave and controller registers
    // ------------------------------------------------------------------
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            bvalid_reg    <= 1'b0;
            bresp_reg     <= `FQTR_RESP_OKAY;
            rvalid_reg    <= 1'b0;
            rresp_reg     <= `FQTR_RESP_OKAY;
            rdata_bus_reg <= 32'h00000000;
            addr_reg      <= `FQTR_ADDR_RST;
            wdata_reg     <= `FQTR_BYTE_RST;
            wr_reg        <= 1'b0;
        end else begin
            // address and data taken in either order
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= `FQTR_RESP_OKAY;
                // address and byte are frozen while an access runs
                case (aw_addr_reg)
                    `FQTR_REG_CTRL: begin
                        if (go) begin
                            wr_reg <= w_data_reg[`FQTR_CTRL_WR];
                        end
                    end
                    `FQTR_REG_ADDR: begin
                        if (!busy) begin
                            addr_reg <= (w_data_reg[AW-1:0] & wmask[AW-1:0])
                                        | (addr_reg & ~wmask[AW-1:0]);
                        end
                    end
                    `FQTR_REG_WDATA: begin
                        if (!busy && w_strb_reg[0]) begin
                            wdata_reg <= wbyte_low;
                        end
                    end
                    `FQTR_REG_STATUS: bresp_reg <= `FQTR_RESP_OKAY;
                    `FQTR_REG_RDATA: bresp_reg <= `FQTR_RESP_OKAY;
                    default: bresp_reg <= `FQTR_RESP_SLVERR;
                endcase
            end else if (bvalid_reg && S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
            end
            // read answer one cycle after the address is taken
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= `FQTR_RESP_OKAY;
                case (S_AXI_ARADDR)
                    `FQTR_REG_CTRL:   rdata_bus_reg <= {30'h0, wr_reg, busy};
                    `FQTR_REG_ADDR:   rdata_bus_reg <= {{(32-AW){1'b0}}, addr_reg};
                    `FQTR_REG_WDATA:  rdata_bus_reg <= {24'h0, wdata_reg};
                    `FQTR_REG_STATUS: rdata_bus_reg <= status;
                    `FQTR_REG_RDATA:  rdata_bus_reg <= {24'h0, rdata_reg};
                    default: begin
                        rdata_bus_reg <= 32'h00000000;
                        rresp_reg     <= `FQTR_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_reg && S_AXI_RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // power-up wait loaded once after reset release
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pu_armed_reg <= 1'b0;
        end else begin
            pu_armed_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
    assign S_AXI_WREADY  = !w_hold_reg && !bvalid_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_ARREADY = !rvalid_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_bus_reg;
    assign S_AXI_RRESP   = rresp_reg;
    assign FLASH_ADDR    = addr_reg;
    assign FLASH_CE_N    = ce_n_reg;
    assign FLASH_WE_N    = we_n_reg;
    assign FLASH_OE_N    = oe_n_reg;
    assign FLASH_DQ_OUT  = wdata_reg;
    assign FLASH_DQ_OE   = dq_oe_reg;
endmodule

`default_nettype wire

/* File: hw/fqtr_host_regs.vh */
`ifndef FQTR_HOST_REGS_VH
`define FQTR_HOST_REGS_VH

// ----------------------------------------------------------------------
// register offsets of the controller (byte addresses, one word each)
// ----------------------------------------------------------------------
`define FQTR_REG_CTRL       8'h00
`define FQTR_REG_ADDR       8'h04
`define FQTR_REG_WDATA      8'h08
`define FQTR_REG_STATUS     8'h0c
`define FQTR_REG_RDATA      8'h10

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define FQTR_CTRL_GO        0
`define FQTR_CTRL_WR        1
`define FQTR_ST_BUSY        0
`define FQTR_ST_QUERY       1
`define FQTR_ST_AUTOSEL     2
`define FQTR_ST_MISMATCH    3
`define FQTR_ST_INHIBIT     4
`define FQTR_ADDR_RST       23'h000000
`define FQTR_BYTE_RST       8'h00

// ----------------------------------------------------------------------
// bus answers and flash command bytes
// ----------------------------------------------------------------------
`define FQTR_RESP_OKAY      2'b00
`define FQTR_RESP_SLVERR    2'b10
`define FQTR_CMD_QUERY      8'h98
`define FQTR_CMD_RESET      8'hf0
`define FQTR_CMD_AUTOSEL    8'h90

// ----------------------------------------------------------------------
// query table window and timing figures in nanoseconds
// ----------------------------------------------------------------------
`define FQTR_TBL_FIRST      8'h10
`define FQTR_TBL_LAST       8'h4f
`define FQTR_CLK_NS         25
`define FQTR_T_AS_NS        25
`define FQTR_T_WP_NS        50
`define FQTR_T_DH_NS        25
`define FQTR_T_ACC_NS       100
`define FQTR_T_PU_NS        1000

`endif

/* File: hw/fqtr_sync.v */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// two-flop synchroniser for pin inputs
// ----------------------------------------------------------------------
module fqtr_sync #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_reg;   // first stage, read only by the second
    reg [W-1:0] sync_reg;   // second stage, safe to use

    // plain double flop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule

`default_nettype wire

/* File: tb/fqtr_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// flash device: command decode and query table only
// ------------------------------------------------------------
module fqtr_flash_model (
    input  wire logic [22:0] addr,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [7:0]  dq_o,
    input  wire logic        dq_oe,
    output logic      [7:0]  dq_i
);
    logic       query = 1'b0;
    logic       autosel = 1'b0;
    logic       inhib = 1'b0;
    logic [7:0] hold = 8'ha5;  // released bus shows the inverse, never a stale byte
    // write cycle spans later fall to earlier rise
    wire        wr = !ce_n && !we_n && oe_n;
    wire        rd = !ce_n && !oe_n;
    // table bytes, 4fh at the top
    localparam logic [511:0] TBL = {128'h00c5b500000004010402013131495250,
        128'h00000000000000000000000000000001, 128'h00007f01000000001700040005000a00,
        128'h04000036270000000000400002595251};
    function automatic logic [7:0] tbl(input logic [22:0] a);
        tbl = (a >= 23'h10 && a <= 23'h4f) ? TBL[(int'(a) - 16) * 8 +: 8] : 8'h00;
    endfunction
    wire [7:0] val = query ? tbl(addr) : (addr[7:0] ^ 8'h3c);
    assign dq_i = dq_oe ? dq_o : (rd ? val : hold);
    // strobes low while powering up block the first write
    initial #1 inhib = wr;
    // data taken at the earlier rise
    always @(negedge wr) begin
        if (inhib) inhib = 1'b0;
        else if (dq_o == 8'h98) query = 1'b1;
        else if (dq_o == 8'hf0 && query) query = 1'b0;
        else if (dq_o == 8'hf0) autosel = 1'b0;
        else if (dq_o == 8'h90) autosel = 1'b1;
    end
    always @(negedge rd) hold <= ~val;
endmodule
`default_nettype wire

/* File: tb/fqtr_host_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// flash strobe checks
// ------------------------------------------------------------
module fqtr_host_asserts #(
    parameter PU_CYC = 40
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic [22:0] FLASH_ADDR,
    input  wire logic        FLASH_CE_N,
    input  wire logic        FLASH_WE_N,
    input  wire logic        FLASH_OE_N,
    input  wire logic [7:0]  FLASH_DQ_OUT,
    input  wire logic        FLASH_DQ_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    int unsigned pu_cnt;  // cycles since reset release, saturating
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) pu_cnt <= 0;
        else if (pu_cnt < PU_CYC) pu_cnt <= pu_cnt + 1;
    end
    chk_pu_idle: assert property (pu_cnt < PU_CYC |-> FLASH_CE_N)
        else $error("chip select during power-up wait");
    chk_wr_combo: assert property (!FLASH_WE_N |-> !FLASH_CE_N && FLASH_OE_N)
        else $error("write strobe without select or with output enable");
    chk_rd_we_high: assert property (!FLASH_OE_N |-> FLASH_WE_N && !FLASH_DQ_OE)
        else $error("read with write strobe or driven data");
    chk_addr_steady: assert property (!FLASH_CE_N |-> $stable(FLASH_ADDR))
        else $error("address moved while selected");
    chk_data_setup: assert property ($fell(FLASH_WE_N) |-> $past(FLASH_DQ_OE))
        else $error("data not driven before write strobe");
    chk_data_hold: assert property ($rose(FLASH_WE_N) |-> FLASH_DQ_OE && $stable(FLASH_DQ_OUT))
        else $error("data not held past write strobe");
    chk_pulse_len: assert property ($fell(FLASH_WE_N) |-> !FLASH_WE_N [*2])
        else $error("write pulse too short");
    chk_read_len: assert property ($fell(FLASH_OE_N) |-> !FLASH_OE_N [*5])
        else $error("read cycle too short");
endmodule
bind fqtr_host fqtr_host_asserts #(.PU_CYC(PU_CYC)) chk (.*);
`default_nettype wire

/* File: tb/fqtr_host_test.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// bench: register tasks over the bus, flash model behind
// ------------------------------------------------------------
module fqtr_host_test;
    logic        CLOCK = 1'b0;
    logic        RST_N = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    wire         aw_rdy, w_rdy, b_v, ar_rdy, r_v, ce_n, we_n, oe_n, dq_oe;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [22:0]  faddr;
    wire [7:0]   dq_in, dq_out;
    int          miscompares = 0, checks_done = 0;
    fqtr_host #(.PU_CYC(20)) uut (.CLOCK(CLOCK), .RST_N(RST_N), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(b_v),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(r_v),
        .S_AXI_RREADY(rready), .FLASH_ADDR(faddr), .FLASH_CE_N(ce_n), .FLASH_WE_N(we_n),
        .FLASH_OE_N(oe_n), .FLASH_DQ_IN(dq_in), .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe));
    fqtr_flash_model flash (.addr(faddr), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .dq_o(dq_out), .dq_oe(dq_oe), .dq_i(dq_in));
    initial forever #12.5 CLOCK = ~CLOCK;
    task automatic conclude;
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmpd(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic cmpr(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: response %b, wanted %b", $time, got, exp);
        end
    endtask
    // a wait that ran out ends the run
    task automatic limit(input int n);
        if (n >= 64) begin
            miscompares++;
            $display("unexpected at %0t: no answer", $time);
            conclude;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic pa, pw;
        @(posedge CLOCK);
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        // ready is sampled mid-cycle, so release lands on the taking edge
        for (n = 0; n < 64 && (pa || pw); n++) begin
            @(negedge CLOCK);
            if (aw_rdy) pa = 1'b0;
            if (w_rdy) pw = 1'b0;
            @(posedge CLOCK);
            if (!pa) awv <= 1'b0;
            if (!pw) wv <= 1'b0;
        end
        limit(n);
        for (n = 0; n < 64; n++) begin
            @(negedge CLOCK);
            if (b_v) break;
        end
        limit(n);
        r = bresp;
        @(posedge CLOCK);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge CLOCK);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(negedge CLOCK);
            if (ar_rdy) break;
        end
        limit(n);
        @(posedge CLOCK);
        arv <= 1'b0;
        for (n = 0; n < 64; n++) begin
            @(negedge CLOCK);
            if (r_v) break;
        end
        limit(n);
        d = rdata;
        r = rresp;
        @(posedge CLOCK);
        rready <= 1'b0;
    endtask
    // one flash access: address, data, go, poll busy, fetch byte
    task automatic fop(input logic w, input logic [22:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        logic [1:0] r;
        int         n;
        wr(8'h04, {9'h0, a}, r);
        wr(8'h08, {24'h0, d}, r);
        wr(8'h00, {30'h0, w, 1'b1}, r);
        for (n = 0; n < 64; n++) begin
            rd(8'h0c, q, r);
            if (q[0] === 1'b0) break;
        end
        limit(n);
        rd(8'h10, q, r);
    endtask
    initial begin
        logic [31:0] q;
        logic [1:0]  r;
        int          n;
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        wr(8'h00, 32'h3, r);  // go during the power-up wait is dropped
        for (n = 0; n < 64; n++) begin
            rd(8'h0c, q, r);
            if (q[4] === 1'b0) break;
        end
        limit(n);
        cmpd(q & 32'h1f, 32'h0);
        wr(8'h14, 32'h1, r);
        cmpr(r, 2'b10);
        rd(8'h14, q, r);
        cmpr(r, 2'b10);
        cmpd(q, 32'h0);
        $display("test power-up done");
        fop(1'b1, 23'h5aa5a5, 8'h98, q);
        rd(8'h0c, q, r);
        cmpd(q & 32'h1f, 32'h2);
        for (n = 16; n < 80; n++) begin
            if (n < 61 || n > 63) fop(1'b0, n[22:0], 8'h00, q);
            if (n < 61 || n > 63) cmpd(q, {24'h0, flash.tbl(n[22:0])});
        end
        rd(8'h0c, q, r);
        cmpd(q & 32'h8, 32'h0);
        $display("test query table done");
        fop(1'b1, 23'h7fffff, 8'h33, q);
        fop(1'b1, 23'h7fffff, 8'hf0, q);
        fop(1'b0, 23'h10, 8'h00, q);
        cmpd(q, 32'h2c);
        cmpd({30'h0, flash.autosel, flash.query}, 32'h0);
        $display("test reset to read done");
        fop(1'b1, 23'h555, 8'h90, q);
        fop(1'b1, 23'h0, 8'h98, q);
        fop(1'b0, 23'h11, 8'h00, q);
        cmpd(q, 32'h52);
        fop(1'b1, 23'h0, 8'hf0, q);
        rd(8'h0c, q, r);
        cmpd(q & 32'h6, 32'h4);
        cmpd({30'h0, flash.autosel, flash.query}, 32'h2);
        $display("test autoselect return done");
        conclude;
    end
endmodule
`default_nettype wire
